// [hdl/asp_baud.sv]
// Baud generator producing one sample tick per effective divisor period
`timescale 1ns/10ps
`default_nettype none
module asp_baud #(
	parameter int DIV_W = 13
) (
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	input  wire logic   ce_i,
	asp_baud_if.gen     bif
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} asp_gen_state_type;

	asp_gen_state_type s_reg, s_next;
	logic [DIV_W-1:0]  eff_div;

	if (DIV_W < 2) begin : g_chk
		$error("asp_baud: DIV_W below 2");
	end

	// Effective divisor, low bit dropped in infrared mode
	assign eff_div = bif.ir ? {1'b0, bif.divisor[DIV_W-1:1]} :
		bif.divisor; // R13 R14

	// Count divisor periods; hold count while not running
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (eff_div == '0) begin
			s_next.cnt = '0; // R17
		end else if (bif.run) begin
			if (s_reg.cnt >= eff_div - 1'b1) begin
				s_next.cnt = '0;
				s_next.tick = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt + 1'b1;
			end
		end
	end

	// State register, frozen while clock enable is low
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign bif.tick = s_reg.tick;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	chk_zero_div_quiet: assert property ( // R17
		eff_div == '0 && $stable(eff_div) |=> !bif.tick
	) else $error("tick with zero divisor");
	chk_tick_needs_run: assert property (
		bif.tick |-> $past(bif.run)
	) else $error("tick without run");
	cov_tick: cover property (bif.tick);
endmodule // asp_baud
`default_nettype wire

// [hdl/asp_top.sv]
// Serial port: APB registers, baud control, transmitter and receiver
//
// How it works
// R01 - Chip run modes do not matter; only wait and stop change behaviour.
// R02 - Stop-in-wait clear: port keeps running through wait mode.
// R03 - Stop-in-wait set: wait freezes baud and frames; resumes after wait.
// R04 - Writing stop-in-wait leaves transmit and receive enables untouched.
// R05 - Reset during wait aborts frames and returns port to reset state.
// R06 - Stop mode freezes everything, keeps registers; reset aborts.
// R07 - Output idles high; output enable off while transmitter disabled.
// R08 - Input high means idle; input ignored while receiver disabled.
// R09 - Board keeps the input pin at a defined level.
// R10 - Reserved locations ignore writes and read as zero.
// R11 - High baud: infrared, pulse code, divisor 12:8; low: divisor 7:0.
// R12 - Infrared bit routes both paths through the pulse stage.
// R13 - Standard rate is clock over sixteen times the divisor.
// R14 - Infrared rate is clock over thirty-two times divisor 12:1.
// R15 - Pulse code 00 gives 3/16, 01 gives 1/16, 10 gives 1/32.
// R16 - Baud generator idle until transmit or receive first enabled.
// R17 - Baud generator held off while effective divisor is zero.
// R18 - High baud write held until low baud write commits both.
// R19 - High baud reads old value until low baud is written.
// R20 - Data low byte holds characters; high byte holds ninth bits.
`timescale 1ns/10ps
`default_nettype none
`include "asp_map.svh"
module asp_top (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	input  wire logic        wait_mode_i,
	input  wire logic        stop_mode_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        rxd_i,
	output logic             txd_o,
	output logic             txd_oe_o
);
	typedef struct packed {
		logic [7:0]                bdh_hold;
		logic [7:0]                bdh;
		logic [7:0]                bdl;
		logic [7:0]                cr1;
		logic [7:0]                cr2;
		logic [1:0]                sr2w;
		logic                      tdre;
		logic                      tc;
		logic                      rdrf;
		logic                      ovr;
		logic                      ferr;
		logic                      started;
		logic                      t8;
		logic [8:0]                tx_buf;
		logic [8:0]                tx_sh;
		asp_pkg::asp_tx_state_type tx_st;
		logic [5:0]                tx_sub;
		logic [3:0]                tx_idx;
		logic                      rx_s1;
		logic                      rx_s2;
		asp_pkg::asp_rx_state_type rx_st;
		logic [5:0]                rx_sub;
		logic [3:0]                rx_idx;
		logic [8:0]                rx_sh;
		logic                      rx_low;
		logic [8:0]                rx_data;
		logic                      txd;
		logic                      oe;
		logic [31:0]               prdata;
		logic                      pready;
	} asp_state_type;

	asp_state_type s_reg, s_next;
	logic          ce_eff;
	logic          halt;
	logic          tick;
	logic          setup;
	logic          acc_wr;
	logic          acc_rd;
	logic          ir;
	logic [5:0]    spb;
	logic [5:0]    pw;
	logic          rx_in;
	logic          bit_v;
	logic          smp;

	asp_baud_if #(.DIV_W(13)) bif ();

	// Address match for one aligned register word
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Pulse width in ticks at thirty-two ticks per bit
	function automatic logic [5:0] pulse_ticks(input logic [1:0] code);
		case (code)
			2'b00: return `ASP_PW_3_16; // R15
			2'b01: return `ASP_PW_1_16; // R15
			2'b10: return `ASP_PW_1_32; // R15
			default: return `ASP_PW_3_16;
		endcase
	endfunction

	// Read mux; reserved and unaligned locations give zero
	function automatic logic [31:0] rd_word(input logic [7:0] a,
		input asp_state_type s);
		logic [7:0] b;
		b = 8'h00; // R10
		if (hit(a, `ASP_OFF_BDH)) b = s.bdh; // R11 R19
		if (hit(a, `ASP_OFF_BDL)) b = s.bdl; // R11
		if (hit(a, `ASP_OFF_CR1)) b = s.cr1;
		if (hit(a, `ASP_OFF_CR2)) b = s.cr2;
		if (hit(a, `ASP_OFF_SR1))
			b = {s.tdre, s.tc, s.rdrf, 1'b0, s.ovr, 1'b0, s.ferr, 1'b0};
		if (hit(a, `ASP_OFF_SR2))
			b = {5'h00, s.sr2w, s.rx_st != asp_pkg::ASP_RX_IDLE};
		if (hit(a, `ASP_OFF_DRH))
			b = {s.rx_data[8], s.t8, 6'h00}; // R20
		if (hit(a, `ASP_OFF_DRL)) b = s.rx_data[7:0]; // R20
		return {24'h000000, b};
	endfunction

	// Stop gates all state; wait halts frames only with stop-in-wait
	assign ce_eff = ce_i & ~stop_mode_i; // R01 R06
	assign halt = wait_mode_i & s_reg.cr1[`ASP_SWAI_BIT]; // R02 R03
	assign tick = bif.tick & ~halt; // R03

	// Baud generator control
	assign bif.run = s_reg.started & ~halt; // R16 R03
	assign bif.ir = s_reg.bdh[`ASP_IR_BIT];
	assign bif.divisor = {s_reg.bdh[4:0], s_reg.bdl}; // R11

	// Bus phase decode
	assign setup = psel_i & ~penable_i & ~s_reg.pready;
	assign acc_wr = psel_i & penable_i & s_reg.pready & pwrite_i;
	assign acc_rd = psel_i & penable_i & s_reg.pready & ~pwrite_i;

	// Mode-dependent timing and receive input
	assign ir = s_reg.bdh[`ASP_IR_BIT]; // R12
	assign spb = ir ? `ASP_SPB_IR : `ASP_SPB_STD; // R13 R14
	assign pw = pulse_ticks(s_reg.bdh[`ASP_NP_HI:`ASP_NP_LO]);
	assign rx_in = s_reg.cr2[`ASP_RE_BIT] ? s_reg.rx_s2 : 1'b1; // R08
	assign smp = ir ? ~(s_reg.rx_low | ~rx_in) : rx_in; // R12

	// Next state: bus access first, then transmitter and receiver
	always_comb begin
		s_next = s_reg;
		bit_v = 1'b1;
		s_next.rx_s1 = rxd_i;
		s_next.rx_s2 = s_reg.rx_s1;
		s_next.pready = setup;
		if (setup) begin
			s_next.prdata = rd_word(paddr_i, s_reg);
		end
		if (acc_wr) begin
			if (hit(paddr_i, `ASP_OFF_BDH))
				s_next.bdh_hold = pwdata_i[7:0]; // R18
			if (hit(paddr_i, `ASP_OFF_BDL)) begin
				s_next.bdh = s_reg.bdh_hold; // R18
				s_next.bdl = pwdata_i[7:0];
			end
			if (hit(paddr_i, `ASP_OFF_CR1))
				s_next.cr1 = pwdata_i[7:0]; // R04
			if (hit(paddr_i, `ASP_OFF_CR2))
				s_next.cr2 = pwdata_i[7:0];
			if (hit(paddr_i, `ASP_OFF_SR2))
				s_next.sr2w = pwdata_i[2:1];
			if (hit(paddr_i, `ASP_OFF_DRH))
				s_next.t8 = pwdata_i[`ASP_T8_BIT]; // R20
			if (hit(paddr_i, `ASP_OFF_DRL)) begin
				s_next.tx_buf = {s_next.t8, pwdata_i[7:0]}; // R20
				s_next.tdre = 1'b0;
				s_next.tc = 1'b0;
			end
		end
		if (acc_rd && hit(paddr_i, `ASP_OFF_DRL)) begin
			s_next.rdrf = 1'b0;
			s_next.ovr = 1'b0;
			s_next.ferr = 1'b0;
		end
		s_next.started = s_reg.started | s_next.cr2[`ASP_TE_BIT] |
			s_next.cr2[`ASP_RE_BIT]; // R16

		// Transmitter
		if (!s_reg.cr2[`ASP_TE_BIT]) begin
			s_next.tx_st = asp_pkg::ASP_TX_IDLE;
			s_next.tx_sub = 6'd0;
		end else if (tick) begin
			s_next.tx_sub = s_reg.tx_sub + 6'd1;
			case (s_reg.tx_st)
				asp_pkg::ASP_TX_IDLE: begin
					s_next.tx_sub = 6'd0;
					if (!s_reg.tdre) begin
						s_next.tx_sh = s_reg.tx_buf;
						s_next.tdre = ~(acc_wr & hit(paddr_i, `ASP_OFF_DRL));
						s_next.tc = 1'b0;
						s_next.tx_st = asp_pkg::ASP_TX_START;
					end
				end
				asp_pkg::ASP_TX_START: begin
					if (s_reg.tx_sub == spb - 6'd1) begin
						s_next.tx_sub = 6'd0;
						s_next.tx_idx = 4'd0;
						s_next.tx_st = asp_pkg::ASP_TX_DATA;
					end
				end
				asp_pkg::ASP_TX_DATA: begin
					if (s_reg.tx_sub == spb - 6'd1) begin
						s_next.tx_sub = 6'd0;
						s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
						s_next.tx_idx = s_reg.tx_idx + 4'd1;
						if (s_reg.tx_idx == (s_reg.cr1[`ASP_M_BIT] ? 4'd8 : 4'd7))
							s_next.tx_st = asp_pkg::ASP_TX_STOP;
					end
				end
				asp_pkg::ASP_TX_STOP: begin
					if (s_reg.tx_sub == spb - 6'd1) begin
						s_next.tx_sub = 6'd0;
						s_next.tx_st = asp_pkg::ASP_TX_IDLE;
						s_next.tc = s_next.tdre;
					end
				end
				default: s_next.tx_st = asp_pkg::ASP_TX_IDLE;
			endcase
		end
		// Line level; infrared sends a narrow low pulse per zero bit
		case (s_next.tx_st)
			asp_pkg::ASP_TX_START: bit_v = 1'b0;
			asp_pkg::ASP_TX_DATA: bit_v = s_next.tx_sh[0];
			default: bit_v = 1'b1;
		endcase
		if (ir && s_next.tx_sub >= pw)
			bit_v = 1'b1; // R12 R15
		s_next.txd = ~s_next.cr2[`ASP_TE_BIT] | bit_v; // R07
		s_next.oe = s_next.cr2[`ASP_TE_BIT]; // R07

		// Receiver, sampled mid-bit; infrared keeps any low seen
		if (!s_reg.cr2[`ASP_RE_BIT]) begin
			s_next.rx_st = asp_pkg::ASP_RX_IDLE; // R08
			s_next.rx_sub = 6'd0;
		end else if (tick) begin
			s_next.rx_sub = s_reg.rx_sub + 6'd1;
			s_next.rx_low = s_reg.rx_low | ~rx_in;
			case (s_reg.rx_st)
				asp_pkg::ASP_RX_IDLE: begin
					s_next.rx_sub = 6'd0;
					s_next.rx_low = 1'b0;
					if (!rx_in)
						s_next.rx_st = asp_pkg::ASP_RX_START; // R08
				end
				asp_pkg::ASP_RX_START: begin
					if (s_reg.rx_sub == (spb >> 1) - 6'd1) begin
						s_next.rx_sub = 6'd0;
						s_next.rx_idx = 4'd0;
						s_next.rx_low = 1'b0;
						s_next.rx_st = (ir || !rx_in) ?
							asp_pkg::ASP_RX_DATA : asp_pkg::ASP_RX_IDLE;
					end
				end
				asp_pkg::ASP_RX_DATA: begin
					if (s_reg.rx_sub == spb - 6'd1) begin
						s_next.rx_sub = 6'd0;
						s_next.rx_low = 1'b0;
						s_next.rx_sh = {smp, s_reg.rx_sh[8:1]};
						s_next.rx_idx = s_reg.rx_idx + 4'd1;
						if (s_reg.rx_idx == (s_reg.cr1[`ASP_M_BIT] ? 4'd8 : 4'd7))
							s_next.rx_st = asp_pkg::ASP_RX_STOP;
					end
				end
				asp_pkg::ASP_RX_STOP: begin
					if (s_reg.rx_sub == spb - 6'd1) begin
						s_next.rx_sub = 6'd0;
						s_next.rx_low = 1'b0;
						s_next.rx_st = asp_pkg::ASP_RX_IDLE;
						if (!smp)
							s_next.ferr = 1'b1;
						if (s_next.rdrf) begin
							s_next.ovr = 1'b1;
						end else begin
							s_next.rdrf = 1'b1;
							s_next.rx_data = s_reg.cr1[`ASP_M_BIT] ? s_reg.rx_sh :
								{1'b0, s_reg.rx_sh[8:1]}; // R20
						end
					end
				end
				default: s_next.rx_st = asp_pkg::ASP_RX_IDLE;
			endcase
		end
	end

	// State register; reset aborts frames in any mode
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_reg <= '0; // R05 R06
			s_reg.tdre <= 1'b1;
			s_reg.tc <= 1'b1;
			s_reg.txd <= 1'b1;
			s_reg.rx_s1 <= 1'b1;
			s_reg.rx_s2 <= 1'b1;
		end else if (ce_eff) begin
			s_reg <= s_next; // R06
		end
	end

	asp_baud #(.DIV_W(13)) u_baud (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_eff),
		.bif     (bif)
	);

	// Outputs straight from state flops; pslverr_o tied low
	assign prdata_o = s_reg.prdata;
	assign pready_o = s_reg.pready;
	assign pslverr_o = 1'b0;
	assign txd_o = s_reg.txd;
	assign txd_oe_o = s_reg.oe;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	chk_oe_follows_te: assert property ( // R07
		txd_oe_o == s_reg.cr2[`ASP_TE_BIT]
	) else $error("output enable differs from transmit enable");
	chk_idle_line_high: assert property ( // R07
		s_reg.tx_st == asp_pkg::ASP_TX_IDLE |-> txd_o
	) else $error("line not high while idle");
	chk_rx_off_idle: assert property ( // R08
		ce_eff && !s_reg.cr2[`ASP_RE_BIT] |=> s_reg.rx_st == asp_pkg::ASP_RX_IDLE
	) else $error("receiver active while disabled");
	chk_halt_freeze: assert property ( // R03
		halt && !$past(acc_wr) && $past(halt) |=>
			$stable(s_reg.tx_sub) && $stable(s_reg.rx_sub)
	) else $error("frame advanced while halted");
	chk_bdh_held: assert property ( // R18
		ce_eff && acc_wr && hit(paddr_i, `ASP_OFF_BDH) |=>
			$stable(s_reg.bdh) && $stable(s_reg.bdl)
	) else $error("divisor changed on high byte write");
	chk_bdl_commit: assert property ( // R18
		ce_eff && acc_wr && hit(paddr_i, `ASP_OFF_BDL) |=>
			s_reg.bdh == $past(s_reg.bdh_hold) &&
			s_reg.bdl == $past(pwdata_i[7:0])
	) else $error("divisor not committed on low byte write");
	chk_unmapped_zero: assert property ( // R10
		ce_eff && setup && paddr_i[4:0] == 5'h00 && paddr_i[7:5] != 3'h0 |=>
			prdata_o == 32'h00000000 && pready_o
	) else $error("reserved location not zero");
	chk_not_started: assert property ( // R16
		!s_reg.started |-> !bif.tick
	) else $error("baud generator ran before enable");
	chk_enables_kept: assert property ( // R04
		ce_eff && acc_wr && hit(paddr_i, `ASP_OFF_CR1) |=> $stable(s_reg.cr2)
	) else $error("enables changed by control one write");

	cov_tx_done: cover property ($rose(s_reg.tc));
	cov_rx_char: cover property ($rose(s_reg.rdrf));
	cov_halt_frame: cover property (halt &&
		s_reg.tx_st != asp_pkg::ASP_TX_IDLE);
	cov_ir_frame: cover property (ir && $rose(s_reg.rdrf));
endmodule // asp_top
`default_nettype wire

// [inc/asp_baud_if.sv]
// Link between port control and the baud generator
`timescale 1ns/10ps
`default_nettype none
interface asp_baud_if #(parameter int DIV_W = 13);
	logic             run;
	logic             ir;
	logic [DIV_W-1:0] divisor;
	logic             tick;
	modport ctrl (output run, ir, divisor, input tick);
	modport gen  (input run, ir, divisor, output tick);
endinterface
`default_nettype wire

// [inc/asp_map.svh]
// Register offsets, field positions, reset values and counts
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_OFF_BDH  8'h00
`define ASP_OFF_BDL  8'h04
`define ASP_OFF_CR1  8'h08
`define ASP_OFF_CR2  8'h0c
`define ASP_OFF_SR1  8'h10
`define ASP_OFF_SR2  8'h14
`define ASP_OFF_DRH  8'h18
`define ASP_OFF_DRL  8'h1c
`define ASP_IR_BIT   7
`define ASP_NP_HI    6
`define ASP_NP_LO    5
`define ASP_SWAI_BIT 6
`define ASP_M_BIT    4
`define ASP_TE_BIT   3
`define ASP_RE_BIT   2
`define ASP_TDRE_BIT 7
`define ASP_TC_BIT   6
`define ASP_RDRF_BIT 5
`define ASP_OR_BIT   3
`define ASP_FE_BIT   1
`define ASP_R8_BIT   7
`define ASP_T8_BIT   6
`define ASP_RST_BYTE 8'h00
`define ASP_SPB_STD  6'd16
`define ASP_SPB_IR   6'd32
`define ASP_PW_3_16  6'd6
`define ASP_PW_1_16  6'd2
`define ASP_PW_1_32  6'd1
`endif

// [inc/asp_pkg.sv]
// Types shared by the serial port modules
package asp_pkg;
	typedef enum logic [1:0] {
		ASP_TX_IDLE  = 2'b00,
		ASP_TX_START = 2'b01,
		ASP_TX_DATA  = 2'b10,
		ASP_TX_STOP  = 2'b11
	} asp_tx_state_type;
	typedef enum logic [1:0] {
		ASP_RX_IDLE  = 2'b00,
		ASP_RX_START = 2'b01,
		ASP_RX_DATA  = 2'b10,
		ASP_RX_STOP  = 2'b11
	} asp_rx_state_type;
endpackage

// [verif/asp_remote.sv]
// Remote serial device model facing the port's two pins
`timescale 1ns/10ps
`default_nettype none
module asp_remote (
	input  wire logic        clk_i,
	input  wire logic        line_i,
	input  wire logic        hold_i,
	input  wire logic [15:0] bit_clks_i,
	output logic             rxd_o
);
	logic [7:0] got_q[$];

	// Input pin always held at a known level
	initial rxd_o = 1'b1;

	// Counts live clocks only; halts along with the port
	task automatic tick(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(posedge clk_i);
			if (!hold_i)
				k++;
		end
	endtask

	// Mid-bit sampling of one frame, low bit first
	always begin : rx_proc
		logic [7:0] sh;
		@(negedge line_i);
		tick(bit_clks_i / 2);
		if (line_i === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				tick(bit_clks_i);
				sh[i] = line_i;
			end
			tick(bit_clks_i);
			if (line_i === 1'b1)
				got_q.push_back(sh);
		end
	end

	// Frame out: start low, data, stop high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= f[i];
			tick(bit_clks_i);
		end
	endtask
endmodule // asp_remote
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the serial port block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        wait_mode_i = 1'b0;
	logic        stop_mode_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        txd_o;
	logic        txd_oe_o;
	logic        rxd;
	logic        line;
	logic        swai = 1'b0;
	logic [31:0] rd;
	logic [7:0]  b;
	logic [7:0]  exp_q[$];
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          seed = 37;
	int          w, p;
	int          m_hold = 0, m_bdh = 0, m_bdl = 0, m_cr1 = 0, m_cr2 = 0;

	always #12.5 clk_i = ~clk_i;

	// Pulled-up pin: a released output reads high
	assign line = txd_oe_o ? txd_o : 1'b1;

	asp_top uut (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.ce_i        (1'b1),
		.wait_mode_i (wait_mode_i),
		.stop_mode_i (stop_mode_i),
		.psel_i      (psel_i),
		.penable_i   (penable_i),
		.pwrite_i    (pwrite_i),
		.paddr_i     (paddr_i),
		.pwdata_i    (pwdata_i),
		.prdata_o    (prdata_o),
		.pready_o    (pready_o),
		.pslverr_o   (pslverr_o),
		.rxd_i       (rxd),
		.txd_o       (txd_o),
		.txd_oe_o    (txd_oe_o)
	);

	asp_remote partner (
		.clk_i      (clk_i),
		.line_i     (line),
		.hold_i     (stop_mode_i | (wait_mode_i & swai)),
		.bit_clks_i (16'd16),
		.rxd_o      (rxd)
	);

	task automatic final_report();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Register model: high baud byte waits for the low one
	function automatic void mdl_wr(input logic [7:0] a, input int d);
		case (a)
			8'h00: m_hold = d;
			8'h04: begin
				m_bdh = m_hold;
				m_bdl = d;
			end
			8'h08: m_cr1 = d;
			8'h0c: m_cr2 = d;
			default: ;
		endcase
	endfunction

	function automatic logic [31:0] mdl_rd(input logic [7:0] a);
		case (a)
			8'h00: return m_bdh;
			8'h04: return m_bdl;
			8'h08: return m_cr1;
			8'h0c: return m_cr2;
			default: return 32'h0;
		endcase
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
		mdl_wr(a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check_val(rd, e);
	endtask

	// Awaits one frame at the remote end
	task automatic tx_chk();
		int k;
		k = 0;
		while (partner.got_q.size() == 0 && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		check_val(partner.got_q.size(), 32'd1);
		if (partner.got_q.size() > 0)
			check_val(partner.got_q.pop_front(), exp_q.pop_front());
	endtask

	// Low-power entry mid-frame; the pin must not move
	task automatic frz(input logic s);
		int c;
		logic t;
		c = 0;
		repeat (50) @(posedge clk_i);
		if (s)
			stop_mode_i <= 1'b1;
		else
			wait_mode_i <= 1'b1;
		@(posedge clk_i);
		t = txd_o;
		repeat (200) begin
			@(posedge clk_i);
			if (txd_o !== t)
				c++;
		end
		stop_mode_i <= 1'b0;
		wait_mode_i <= 1'b0;
		check_val(c, 32'd0);
	endtask

	task automatic send_tx();
		b = 8'($random(seed));
		wr(8'h1c, b);
		exp_q.push_back(b);
	endtask

	// Infrared pulse width and spacing of the pulses
	task automatic ir_pulse();
		int k;
		k = 0;
		while (txd_o !== 1'b0 && k < 500) begin
			@(posedge clk_i);
			k++;
		end
		w = 0;
		while (txd_o === 1'b0 && w < 100) begin
			@(posedge clk_i);
			w++;
		end
		p = w;
		while (txd_o === 1'b1 && p < 100) begin
			@(posedge clk_i);
			p++;
		end
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		check_val(txd_oe_o, 1'b0);
		for (int a = 0; a <= 32; a += 4)
			rchk(8'(a), (a == 16) ? 32'hc0 : mdl_rd(8'(a)));
		wr(8'h20, 8'hff);
		rchk(8'h20, 32'h0);
		check_val(pslverr_o, 32'h0);
		$display("test reset values done");
		wr(8'h00, 8'h9f);
		rchk(8'h00, mdl_rd(8'h00));
		wr(8'h04, 8'h5a);
		rchk(8'h00, mdl_rd(8'h00));
		rchk(8'h04, mdl_rd(8'h04));
		$display("test baud latch done");
		wr(8'h00, 8'h80);
		wr(8'h04, 8'h01);
		wr(8'h0c, 8'h0c);
		check_val(txd_oe_o, 1'b1);
		send_tx();
		frz(1'b0);
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h00);
		frz(1'b0);
		wr(8'h04, 8'h01);
		tx_chk();
		for (int i = 0; i < 3; i++) begin
			send_tx();
			tx_chk();
		end
		$display("test transmit done");
		for (int i = 0; i < 2; i++) begin
			b = 8'($random(seed));
			partner.send(b);
			rchk(8'h10, 32'he0);
			rchk(8'h1c, {24'h0, b});
			rchk(8'h10, 32'hc0);
		end
		wr(8'h0c, 8'h08);
		partner.send(8'h3c);
		rchk(8'h10, 32'hc0);
		$display("test receive done");
		wr(8'h0c, 8'h0c);
		wr(8'h08, 8'h10);
		wr(8'h18, 8'h40);
		send_tx();
		tx_chk();
		partner.send(8'ha5);
		repeat (20) @(posedge clk_i);
		rchk(8'h18, 32'hc0);
		rchk(8'h1c, 32'ha5);
		wr(8'h08, 8'h00);
		send_tx();
		wait_mode_i <= 1'b1;
		tx_chk();
		wait_mode_i <= 1'b0;
		swai = 1'b1;
		wr(8'h08, 8'h40);
		rchk(8'h0c, mdl_rd(8'h0c));
		send_tx();
		frz(1'b0);
		tx_chk();
		send_tx();
		frz(1'b1);
		rchk(8'h08, mdl_rd(8'h08));
		tx_chk();
		$display("test low power done");
		wr(8'h1c, 8'h0f);
		repeat (60) @(posedge clk_i);
		wait_mode_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check_val({txd_o, txd_oe_o}, 32'h2);
		reset_i <= 1'b0;
		wait_mode_i <= 1'b0;
		swai = 1'b0;
		{m_hold, m_bdh, m_bdl, m_cr1, m_cr2} = '0;
		@(posedge clk_i);
		for (int a = 0; a <= 16; a += 4)
			rchk(8'(a), (a == 16) ? 32'hc0 : mdl_rd(8'(a)));
		repeat (400) @(posedge clk_i);
		partner.got_q.delete();
		$display("test reset abort done");
		wr(8'h0c, 8'h0c);
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, 8'h80 | 8'(c << 5));
			wr(8'h04, 8'h02);
			wr(8'h1c, 8'h00);
			ir_pulse();
			check_val(w, (c == 1) ? 32 / 16 : (c == 2) ? 32 / 32 : 32 * 3 / 16);
			check_val(p, 32'd32);
			repeat (400) @(posedge clk_i);
		end
		$display("test infrared done");
		final_report();
	end
endmodule // testbench
`default_nettype wire
